// [opad_core.sv]
/*
  Status word and operand locator of an 8-bit core: flags, bank selection,
  and the location or value of each operand per addressing mode.
  Assumes accumulator, pointers and decoded mode arrive from logic on clk_sys.
*/
`timescale 1ns/10ps
// Behaviour
// - Parity flag set when accumulator has odd ones, cleared when even.
// - Two bank bits pick one of four eight-register banks at execution.
// - Status word holds carry, aux carry, bank bits, overflow, parity, two user flags.
// - Carry is the one-bit operand and result of Boolean operations.
// - Direct mode uses 8-bit field, reaching only internal RAM and SFRs.
// - Indirect mode takes location from a register, reaching internal or external RAM.
// - 8-bit pointer is register zero, one or stack pointer; 16-bit is wide pointer.
// - Register mode applies opcode's 3-bit number to the active bank.
// - Register-specific operand comes from opcode alone, no address byte.
// - Immediate operand is the program byte following the opcode.
// - Indexed mode reads program memory at 16-bit base plus accumulator.
// - Case jump target is base pointer plus accumulator.
module opad_core
    import opad_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  acc_value,
    input  wire logic [7:0]  stack_ptr,
    input  wire logic [15:0] wide_data_pointer,
    input  wire logic [15:0] prog_counter,
    input  wire logic        exec_valid,
    input  wire opad_mode_t  exec_mode,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  direct_field,
    input  wire logic [7:0]  imm_byte,
    input  wire opad_ptr_t   ptr_sel,
    input  wire logic        xram_sel,
    input  wire logic        base_is_pc,
    input  wire logic        spec_is_wide_data_pointer,
    input  wire logic        psw_we,
    input  wire logic [7:0]  psw_wdata,
    input  wire logic        cy_we,
    input  wire logic        cy_in,
    input  wire logic        ac_we,
    input  wire logic        ac_in,
    input  wire logic        ov_we,
    input  wire logic        ov_in,
    input  wire opad_bool_t  bool_op,
    input  wire logic        bit_in,
    input  wire logic        rf_we,
    input  wire logic [2:0]  rf_wnum,
    input  wire logic [7:0]  rf_wdata,
    output logic      [7:0]  program_status_word,
    output logic             carry_flag,
    output logic             parity_flag,
    output logic             bank_select_low,
    output logic             bank_select_high,
    output opad_space_t      op_space,
    output logic      [15:0] op_addr,
    output logic      [7:0]  op_value,
    output logic             op_valid,
    output logic      [15:0] jump_target,
    output logic             jump_valid
);

    opad_state_t state;
    opad_state_t next_state;
    logic        acc_odd;
    logic [4:0]  rf_rd_index;
    logic [4:0]  rf_wr_index;
    logic [7:0]  rf_rd_data;

    function automatic logic [4:0] opad_reg_index(input logic rs1, input logic rs0,
                                                  input logic [2:0] num);
        opad_reg_index = {rs1, rs0, num};
    endfunction

    // Carry out of bit 15 is dropped: tables wrap within the 64K space
    function automatic logic [15:0] opad_index_sum(input logic [15:0] base,
                                                   input logic [7:0] acc);
        opad_index_sum = base + {8'h00, acc};
    endfunction

    opad_parity u_parity (
        .data (acc_value),
        .odd  (acc_odd)
    );

    // Bank bits are read live so a bank switch affects the next instruction
    assign rf_wr_index = opad_reg_index(state.psw.rs1, state.psw.rs0, rf_wnum);
    assign rf_rd_index = (exec_mode == MODE_REGISTER) ?
                         opad_reg_index(state.psw.rs1, state.psw.rs0, opcode[2:0]) :
                         opad_reg_index(state.psw.rs1, state.psw.rs0,
                                        {2'b00, ptr_sel == PTR_REG_ONE});

    opad_regfile u_regfile (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .wr_en    (rf_we),
        .wr_index (rf_wr_index),
        .wr_data  (rf_wdata),
        .rd_index (rf_rd_index),
        .rd_data  (rf_rd_data)
    );

    always_comb begin
        next_state            = state;
        next_state.op_valid   = 1'b0;
        next_state.jump_valid = 1'b0;
        // Whole-word write; parity is never writable
        if (psw_we) begin
            next_state.psw    = psw_wdata;
        end
        // Hardware flag updates win over a software write in the same cycle
        if (ac_we) begin
            next_state.psw.ac = ac_in;
        end
        if (ov_we) begin
            next_state.psw.ov = ov_in;
        end
        if (cy_we) begin
            next_state.psw.cy = cy_in;
        end
        unique case (bool_op)
            BOOL_NONE:    next_state.psw.cy = next_state.psw.cy;
            BOOL_MOV:     next_state.psw.cy = bit_in;
            BOOL_AND:     next_state.psw.cy = state.psw.cy & bit_in;
            BOOL_OR:      next_state.psw.cy = state.psw.cy | bit_in;
            BOOL_AND_NOT: next_state.psw.cy = state.psw.cy & ~bit_in;
            BOOL_OR_NOT:  next_state.psw.cy = state.psw.cy | ~bit_in;
            BOOL_CPL:     next_state.psw.cy = ~state.psw.cy;
            BOOL_CLR:     next_state.psw.cy = 1'b0;
        endcase
        // Recomputed every edge, so it lags the accumulator by one cycle
        next_state.psw.p = acc_odd;
        if (exec_valid) begin
            next_state.op_valid = 1'b1;
            next_state.op_value = 8'h00;
            unique case (exec_mode)
                MODE_DIRECT: begin
                    next_state.op_addr  = {8'h00, direct_field};
                    next_state.op_space = (direct_field < DIRECT_SFR_BASE) ?
                                          SPACE_IRAM : SPACE_SFR;
                end
                MODE_INDIRECT8: begin
                    if (ptr_sel == PTR_STACK) begin
                        next_state.op_addr  = {8'h00, stack_ptr};
                        next_state.op_space = SPACE_IRAM;
                    end else begin
                        next_state.op_addr  = {8'h00, rf_rd_data};
                        next_state.op_space = xram_sel ? SPACE_XRAM : SPACE_IRAM;
                    end
                end
                MODE_INDIRECT16: begin
                    next_state.op_addr  = wide_data_pointer;
                    next_state.op_space = SPACE_XRAM;
                end
                MODE_REGISTER: begin
                    // Banks are mapped at the bottom of internal RAM
                    next_state.op_addr  = {11'h000, rf_rd_index};
                    next_state.op_value = rf_rd_data;
                    next_state.op_space = SPACE_IRAM;
                end
                MODE_REG_SPEC: begin
                    next_state.op_addr  = 16'h0000;
                    next_state.op_space = spec_is_wide_data_pointer ? SPACE_WIDE_DATA_POINTER : SPACE_ACC;
                    next_state.op_value = spec_is_wide_data_pointer ? 8'h00 : acc_value;
                end
                MODE_IMMEDIATE: begin
                    next_state.op_addr  = 16'h0000;
                    next_state.op_value = imm_byte;
                    next_state.op_space = SPACE_IMM;
                end
                MODE_INDEXED: begin
                    next_state.op_addr  = opad_index_sum(base_is_pc ? prog_counter :
                                                         wide_data_pointer, acc_value);
                    next_state.op_space = SPACE_CODE;
                end
                MODE_CASE_JUMP: begin
                    // Jump leaves the last operand untouched
                    next_state.op_value    = state.op_value;
                    next_state.op_valid    = 1'b0;
                    next_state.jump_valid  = 1'b1;
                    next_state.jump_target = opad_index_sum(wide_data_pointer,
                                                            acc_value);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= '{psw: PSW_RESET, op_space: SPACE_NONE, default: '0};
        end else begin
            state <= next_state;
        end
    end

    assign program_status_word = state.psw;
    assign carry_flag          = state.psw.cy;
    assign parity_flag         = state.psw.p;
    assign bank_select_low     = state.psw.rs0;
    assign bank_select_high    = state.psw.rs1;
    assign op_space            = state.op_space;
    assign op_addr             = state.op_addr;
    assign op_value            = state.op_value;
    assign op_valid            = state.op_valid;
    assign jump_target         = state.jump_target;
    assign jump_valid          = state.jump_valid;

    // Checks on the driven outputs
    a_parity_tracks_acc: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $past(rst_b) |-> (parity_flag ^ (^$past(acc_value))) == 1'b0)
        else $error("parity flag does not match accumulator ones");

    a_parity_even_sum: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $stable(acc_value) && $past(rst_b) |-> (^{acc_value, parity_flag}) == 1'b0)
        else $error("accumulator plus parity is not even");

    a_direct_space_map: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_DIRECT |=>
        op_addr == {8'h00, $past(direct_field)} &&
        op_space == (($past(direct_field) < DIRECT_SFR_BASE) ? SPACE_IRAM : SPACE_SFR))
        else $error("direct operand location wrong");

    a_register_bank_pick: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_REGISTER |=>
        op_addr[4:0] == {$past(bank_select_high), $past(bank_select_low),
                         $past(opcode[2:0])} && op_value == $past(rf_rd_data))
        else $error("register operand not taken from active bank");

    a_indirect_short_ptr: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_INDIRECT8 && ptr_sel == PTR_STACK |=>
        op_addr == {8'h00, $past(stack_ptr)} && op_space == SPACE_IRAM)
        else $error("stack pointer indirect location wrong");

    a_indirect_ram_space: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_INDIRECT8 && ptr_sel != PTR_STACK |=>
        op_addr[7:0] == $past(rf_rd_data) &&
        op_space == ($past(xram_sel) ? SPACE_XRAM : SPACE_IRAM))
        else $error("register indirect location wrong");

    a_indirect_wide_ptr: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_INDIRECT16 |=>
        op_addr == $past(wide_data_pointer) && op_space == SPACE_XRAM)
        else $error("wide indirect location wrong");

    a_reg_spec_operand: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_REG_SPEC && !spec_is_wide_data_pointer |=>
        op_space == SPACE_ACC && op_value == $past(acc_value))
        else $error("accumulator-specific operand wrong");

    a_immediate_value: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_IMMEDIATE |=>
        op_valid && op_space == SPACE_IMM && op_value == $past(imm_byte))
        else $error("immediate operand wrong");

    a_indexed_code_addr: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_INDEXED |=> op_space == SPACE_CODE &&
        op_addr == 16'(($past(base_is_pc) ? $past(prog_counter) :
                         $past(wide_data_pointer)) + {8'h00, $past(acc_value)}))
        else $error("indexed program address wrong");

    a_case_jump_target: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_CASE_JUMP |=> jump_valid && !op_valid &&
        jump_target == 16'($past(wide_data_pointer) + {8'h00, $past(acc_value)}))
        else $error("case jump target wrong");

    a_carry_bool_and: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        bool_op == BOOL_AND |=> carry_flag == ($past(carry_flag) & $past(bit_in)))
        else $error("Boolean AND result not in carry");

    a_user_flag_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        psw_we && !ac_we && !ov_we |=>
        program_status_word[5] == $past(psw_wdata[5]) &&
        program_status_word[1] == $past(psw_wdata[1]) &&
        program_status_word[2] == $past(psw_wdata[2]))
        else $error("status word write not kept");

    c_case_jump: cover property (
        @(posedge clk_sys) disable iff (!rst_b) jump_valid);

    c_bank_three_reg: cover property (
        @(posedge clk_sys) disable iff (!rst_b)
        exec_valid && exec_mode == MODE_REGISTER && bank_select_high && bank_select_low);

    c_xram_indirect: cover property (
        @(posedge clk_sys) disable iff (!rst_b) op_valid && op_space == SPACE_XRAM);

    c_parity_set: cover property (
        @(posedge clk_sys) disable iff (!rst_b) $rose(parity_flag));

endmodule

// [opad_parity.sv]
/*
  Odd-ones detector for one byte.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
module opad_parity
    import opad_pkg::*;
(
    input  wire logic [7:0] data,
    output logic            odd
);

    assign odd = ^data;

endmodule

// [opad_pkg.sv]
/*
  Shared constants and types for the operand addressing and status word logic.
  Assumes a single core clock domain; every user of it imports the whole package.
*/
package opad_pkg;

    // Status word bit positions
    localparam int PSW_CY_BIT  = 7;
    localparam int PSW_AC_BIT  = 6;
    localparam int PSW_F0_BIT  = 5;
    localparam int PSW_RS1_BIT = 4;
    localparam int PSW_RS0_BIT = 3;
    localparam int PSW_OV_BIT  = 2;
    localparam int PSW_F1_BIT  = 1;
    localparam int PSW_P_BIT   = 0;

    localparam logic [7:0] PSW_RESET       = 8'h00;
    localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
    localparam logic [7:0] REG_CELL_RESET  = 8'h00;
    localparam int         REG_BANKS       = 4;
    localparam int         REGS_PER_BANK   = 8;
    localparam int         REG_CELLS       = REG_BANKS * REGS_PER_BANK;

    typedef enum logic [2:0] {
        MODE_DIRECT    = 3'h0,
        MODE_INDIRECT8 = 3'h1,
        MODE_INDIRECT16 = 3'h2,
        MODE_REGISTER  = 3'h3,
        MODE_REG_SPEC  = 3'h4,
        MODE_IMMEDIATE = 3'h5,
        MODE_INDEXED   = 3'h6,
        MODE_CASE_JUMP = 3'h7
    } opad_mode_t;

    typedef enum logic [2:0] {
        SPACE_NONE = 3'h0,
        SPACE_IRAM = 3'h1,
        SPACE_SFR  = 3'h2,
        SPACE_XRAM = 3'h3,
        SPACE_CODE = 3'h4,
        SPACE_IMM  = 3'h5,
        SPACE_ACC  = 3'h6,
        SPACE_WIDE_DATA_POINTER = 3'h7
    } opad_space_t;

    typedef enum logic [1:0] {
        PTR_REG_ZERO = 2'h0,
        PTR_REG_ONE  = 2'h1,
        PTR_STACK    = 2'h2
    } opad_ptr_t;

    typedef enum logic [2:0] {
        BOOL_NONE    = 3'h0,
        BOOL_MOV     = 3'h1,
        BOOL_AND     = 3'h2,
        BOOL_OR      = 3'h3,
        BOOL_AND_NOT = 3'h4,
        BOOL_OR_NOT  = 3'h5,
        BOOL_CPL     = 3'h6,
        BOOL_CLR     = 3'h7
    } opad_bool_t;

    typedef struct packed {
        logic cy;
        logic ac;
        logic f0;
        logic rs1;
        logic rs0;
        logic ov;
        logic f1;
        logic p;
    } opad_psw_t;

    typedef struct packed {
        logic [REG_CELLS-1:0][7:0] cells;
    } opad_rf_state_t;

    typedef struct packed {
        opad_psw_t   psw;
        opad_space_t op_space;
        logic [15:0] op_addr;
        logic [7:0]  op_value;
        logic        op_valid;
        logic [15:0] jump_target;
        logic        jump_valid;
    } opad_state_t;

endpackage

// [opad_prog_model.sv]
/*
  Program memory stand-in: returns the byte that follows the opcode.
  Assumes the bench holds the program counter at the opcode's address.
*/
`timescale 1ns/10ps
module opad_prog_model (
    input  wire logic [15:0] prog_counter,
    output logic      [7:0]  imm_byte
);
    logic [15:0] next_addr;

    // Contents differ per address so a stale or wrong fetch shows
    always_comb begin
        next_addr = prog_counter + 16'h0001;
        imm_byte  = next_addr[7:0] ^ next_addr[15:8] ^ 8'h3c;
    end
endmodule

// [opad_regfile.sv]
/*
  Four banks of eight working registers in flip-flops, one write and one read port.
  Assumes the caller forms the flat index from bank and register number.
*/
`timescale 1ns/10ps
module opad_regfile
    import opad_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       wr_en,
    input  wire logic [4:0] wr_index,
    input  wire logic [7:0] wr_data,
    input  wire logic [4:0] rd_index,
    output logic      [7:0] rd_data
);

    opad_rf_state_t state;
    opad_rf_state_t next_state;

    // Read is combinational so the pointer is seen in the executing cycle
    assign rd_data = state.cells[rd_index];

    always_comb begin
        next_state = state;
        if (wr_en) begin
            next_state.cells[wr_index] = wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= '{cells: {REG_CELLS{REG_CELL_RESET}}};
        end else begin
            state <= next_state;
        end
    end

endmodule

// [test_cpu_operand_addressing_psw.sv]
/*
  Self-checking bench for the status word and operand locator.
  Assumes the core answers one cycle after each request, as handed over.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_cpu_operand_addressing_psw;
    import opad_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  acc_value = 8'h00, stack_ptr = 8'h00, opcode = 8'h00;
    logic [7:0]  direct_field = 8'h00, psw_wdata = 8'h00, rf_wdata = 8'h00;
    logic [15:0] wide_data_pointer = 16'h0000, prog_counter = 16'h0000;
    logic        exec_valid = 1'b0, xram_sel = 1'b0, base_is_pc = 1'b0;
    logic        spec_is_wide_data_pointer = 1'b0, psw_we = 1'b0, cy_we = 1'b0, cy_in = 1'b0;
    logic        ac_we = 1'b0, ac_in = 1'b0, ov_we = 1'b0, ov_in = 1'b0;
    logic        bit_in = 1'b0, rf_we = 1'b0;
    logic [2:0]  rf_wnum = 3'h0;
    opad_mode_t  exec_mode = MODE_DIRECT;
    opad_ptr_t   ptr_sel = PTR_REG_ZERO;
    opad_bool_t  bool_op = BOOL_NONE;
    logic [7:0]  imm_byte, program_status_word, op_value;
    logic        carry_flag, parity_flag, bank_select_low, bank_select_high;
    logic        op_valid, jump_valid;
    logic [15:0] op_addr, jump_target, pa;
    opad_space_t op_space;
    int          err_count = 0;
    int          total_checks = 0;

    always #20 clk_sys = ~clk_sys;

    opad_prog_model opad_prog_model_i (.prog_counter(prog_counter), .imm_byte(imm_byte));

    opad_core opad_core_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .acc_value(acc_value), .stack_ptr(stack_ptr),
        .wide_data_pointer(wide_data_pointer), .prog_counter(prog_counter),
        .exec_valid(exec_valid), .exec_mode(exec_mode), .opcode(opcode),
        .direct_field(direct_field), .imm_byte(imm_byte), .ptr_sel(ptr_sel),
        .xram_sel(xram_sel), .base_is_pc(base_is_pc), .spec_is_wide_data_pointer(spec_is_wide_data_pointer),
        .psw_we(psw_we), .psw_wdata(psw_wdata), .cy_we(cy_we), .cy_in(cy_in),
        .ac_we(ac_we), .ac_in(ac_in), .ov_we(ov_we), .ov_in(ov_in), .bool_op(bool_op),
        .bit_in(bit_in), .rf_we(rf_we), .rf_wnum(rf_wnum), .rf_wdata(rf_wdata),
        .program_status_word(program_status_word), .carry_flag(carry_flag),
        .parity_flag(parity_flag), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .op_space(op_space), .op_addr(op_addr),
        .op_value(op_value), .op_valid(op_valid), .jump_target(jump_target),
        .jump_valid(jump_valid)
    );

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One request, then the answer and the end of its pulse
    task automatic ex(input opad_mode_t m, input opad_space_t s, input logic [15:0] a,
                      input logic [7:0] v, input bit ca, input bit cv);
        exec_mode = m;
        exec_valid = 1'b1;
        step();
        exec_valid = 1'b0;
        `CHK("op_valid", 1'b1, op_valid)
        `CHK("op_space", s, op_space)
        if (ca) `CHK("op_addr", a, op_addr)
        if (cv) `CHK("op_value", v, op_value)
        step();
        `CHK("op_valid low", 1'b0, op_valid)
    endtask

    task automatic psw_write(input logic [7:0] d);
        psw_wdata = d;
        psw_we = 1'b1;
        step();
        psw_we = 1'b0;
        step();
    endtask

    task automatic t_parity();
        logic [7:0] vals [6] = '{8'h00, 8'hff, 8'h01, 8'h80, 8'h7e, 8'h6b};
        foreach (vals[i]) begin
            acc_value = vals[i];
            step();
            `CHK("parity_flag", ^vals[i], parity_flag)
            `CHK("psw parity", ^vals[i], program_status_word[0])
        end
        acc_value = 8'h00;
        step();
    endtask

    task automatic t_status_word();
        cy_we = 1'b1; cy_in = 1'b1; ac_we = 1'b1; ac_in = 1'b1; ov_we = 1'b1; ov_in = 1'b1;
        psw_write(8'h00);
        cy_we = 1'b0; ac_we = 1'b0; ov_we = 1'b0;
        `CHK("psw flags", 8'hc4, program_status_word)
        psw_write(8'h3b);
        `CHK("psw user bits", 8'h3a, program_status_word)
        `CHK("bank_select_low", 1'b1, bank_select_low)
        `CHK("bank_select_high", 1'b1, bank_select_high)
        psw_write(8'h00);
    endtask

    task automatic t_boolean();
        logic e;
        for (int op = 1; op < 8; op++) begin
            for (int k = 0; k < 4; k++) begin
                cy_we = 1'b1; cy_in = k[1];
                step();
                cy_we = 1'b0; bool_op = opad_bool_t'(op); bit_in = k[0];
                step();
                bool_op = BOOL_NONE;
                case (op)
                    1: e = k[0];
                    2: e = k[1] & k[0];
                    3: e = k[1] | k[0];
                    4: e = k[1] & ~k[0];
                    5: e = k[1] | ~k[0];
                    6: e = ~k[1];
                    default: e = 1'b0;
                endcase
                `CHK("carry_flag", e, carry_flag)
                `CHK("psw carry", e, program_status_word[7])
            end
        end
    endtask

    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            psw_write(8'(b << 3));
            for (int r = 0; r < 3; r++) begin
                rf_we = 1'b1; rf_wnum = (r == 2) ? 3'h7 : 3'(r);
                rf_wdata = (r == 0) ? 8'(8'h10 + b) : (r == 1) ? 8'(8'h90 + b) : 8'(8'hc0 + b);
                step();
            end
            rf_we = 1'b0;
            opcode = 8'hef;
            ex(MODE_REGISTER, SPACE_IRAM, 16'(b * 8 + 7), 8'(8'hc0 + b), 1, 1);
            ptr_sel = PTR_REG_ZERO; xram_sel = 1'b0;
            ex(MODE_INDIRECT8, SPACE_IRAM, 16'(8'h10 + b), 8'h00, 1, 0);
            ptr_sel = PTR_REG_ONE; xram_sel = 1'b1;
            ex(MODE_INDIRECT8, SPACE_XRAM, 16'(8'h90 + b), 8'h00, 1, 0);
            ptr_sel = PTR_STACK; stack_ptr = 8'(8'h47 + b);
            ex(MODE_INDIRECT8, SPACE_IRAM, 16'(8'h47 + b), 8'h00, 1, 0);
        end
        // Banks must not alias: bank 0 still holds its own copy
        psw_write(8'h00);
        ex(MODE_REGISTER, SPACE_IRAM, 16'h0007, 8'hc0, 1, 1);
    endtask

    task automatic t_modes();
        direct_field = 8'h7f;
        ex(MODE_DIRECT, SPACE_IRAM, 16'h007f, 8'h00, 1, 0);
        direct_field = 8'h80;
        ex(MODE_DIRECT, SPACE_SFR, 16'h0080, 8'h00, 1, 0);
        wide_data_pointer = 16'hbeef;
        ex(MODE_INDIRECT16, SPACE_XRAM, 16'hbeef, 8'h00, 1, 0);
        acc_value = 8'h5a; spec_is_wide_data_pointer = 1'b0;
        ex(MODE_REG_SPEC, SPACE_ACC, 16'h0000, 8'h5a, 1, 1);
        spec_is_wide_data_pointer = 1'b1;
        ex(MODE_REG_SPEC, SPACE_WIDE_DATA_POINTER, 16'h0000, 8'h00, 1, 1);
        prog_counter = 16'h12ff;
        pa = prog_counter + 16'h0001;
        ex(MODE_IMMEDIATE, SPACE_IMM, 16'h0000, pa[7:0] ^ pa[15:8] ^ 8'h3c, 0, 1);
        wide_data_pointer = 16'hfffe; acc_value = 8'h05; base_is_pc = 1'b0;
        ex(MODE_INDEXED, SPACE_CODE, 16'h0003, 8'h00, 1, 0);
        base_is_pc = 1'b1; prog_counter = 16'h2000; acc_value = 8'hff;
        ex(MODE_INDEXED, SPACE_CODE, 16'h20ff, 8'h00, 1, 0);
    endtask

    task automatic t_case_jump();
        wide_data_pointer = 16'hff80; acc_value = 8'h90; spec_is_wide_data_pointer = 1'b0;
        ex(MODE_REG_SPEC, SPACE_ACC, 16'h0000, 8'h90, 1, 1);
        exec_mode = MODE_CASE_JUMP;
        exec_valid = 1'b1;
        step();
        exec_valid = 1'b0;
        `CHK("jump_valid", 1'b1, jump_valid)
        `CHK("jump_target", 16'h0010, jump_target)
        `CHK("op_valid on jump", 1'b0, op_valid)
        `CHK("op_value held on jump", 8'h90, op_value)
        `CHK("op_space held on jump", SPACE_ACC, op_space)
        `CHK("op_addr held on jump", 16'h0000, op_addr)
        step();
        `CHK("jump_valid low", 1'b0, jump_valid)
    endtask

    initial begin
        repeat (12) step();
        rst_b = 1'b1;
        `CHK("psw after reset", 8'h00, program_status_word)
        `CHK("space after reset", SPACE_NONE, op_space)
        t_parity();
        t_status_word();
        t_boolean();
        t_banks();
        t_modes();
        t_case_jump();
        tally_and_finish();
    end

    // Whole run is under 160 cycles; this bounds a hang
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
endmodule
